// [rtl/trf_formatter.sv]
// temperature result formatter: range/resolution formatting, limit alarms, AXI4-Lite registers
`timescale 1ns/1ps
module trf_formatter (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // conversion results from the front end
    input wire trf_pkg::trf_conv_t conv,
    // axi4-lite write address
    input wire logic [7:0] s_awaddr,
    input wire logic [2:0] s_awprot,
    input wire logic s_awvalid,
    output logic s_awready,
    // axi4-lite write data
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    // axi4-lite write response
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // axi4-lite read address
    input wire logic [7:0] s_araddr,
    input wire logic [2:0] s_arprot,
    input wire logic s_arvalid,
    output logic s_arready,
    // axi4-lite read data
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // open-drain alarm pins
    output logic limit_alarm_o,
    output logic limit_alarm_oe,
    output logic overheat_flag_out_o,
    output logic overheat_flag_out_oe
);
    import trf_pkg::*;

    // register index: 0..6 fixed registers, 7..12 limits, 15 unmapped
    function automatic logic [3:0] trf_decode(input logic [7:0] addr);
        if (addr[1:0] != 2'h0) begin
            return 4'hf;
        end else if (addr < TRF_OFS_LIM0 + 8'(4 * TRF_NUM_LIM)) begin
            return addr[5:2];
        end else begin
            return 4'hf;
        end
    endfunction : trf_decode

    // mask of kept fraction bits for a resolution select
    function automatic logic [3:0] trf_frac_mask(input logic [1:0] sel);
        return 4'hf << (2'h3 - sel);
    endfunction : trf_frac_mask

    // software-visible control
    logic range_ext_q; // configuration bit 2
    logic [1:0] local_res_q; // {local_res_sel_hi, local_res_sel_lo}
    logic [7:0] lim_q [TRF_NUM_LIM]; // limits, stored exactly as written
    // per-channel results and the settings latched at conversion start
    logic [7:0] res_hi_q [2];
    logic [7:0] res_lo_q [2];
    logic rng_s_q [2];
    logic [1:0] res_s_q [2];
    logic busy_q [2];
    // per-channel compare outcomes
    logic [1:0] over_w;
    logic [1:0] under_w;
    logic [1:0] hot_w;

    // one formatting path per channel
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_ch
            logic mine_w;
            logic signed [15:0] tmp_w;
            logic signed [15:0] lo_lim_w;
            logic signed [15:0] hi_lim_w;
            logic signed [15:0] clamp_w;
            logic [15:0] biased_w;
            logic [3:0] mask_w;
            assign mine_w = (conv.chan == 1'(ch));
            assign tmp_w = 16'(conv.temp);
            // clamp window depends on the range latched at start
            assign lo_lim_w = rng_s_q[ch] ? TRF_EXT_MIN : TRF_STD_MIN;
            assign hi_lim_w = rng_s_q[ch] ? TRF_EXT_MAX : TRF_STD_MAX;
            assign clamp_w = (tmp_w < lo_lim_w) ? lo_lim_w : (tmp_w > hi_lim_w) ? hi_lim_w : tmp_w;
            // extended code is the standard value plus 64 degrees, giving 00h..ffh
            assign biased_w = 16'(rng_s_q[ch] ? clamp_w + TRF_EXT_OFS : clamp_w);
            // remote ignores the select; local truncates toward zero fraction
            assign mask_w = (ch == TRF_CH_REM) ? 4'hf : trf_frac_mask(res_s_q[ch]);
            // compare the stored high byte with limits in whatever encoding software wrote
            assign over_w[ch] = res_hi_q[ch] > lim_q[TRF_LIM_HIGH + 2 * ch];
            assign under_w[ch] = res_hi_q[ch] < lim_q[TRF_LIM_LOW + 2 * ch];
            assign hot_w[ch] = res_hi_q[ch] > lim_q[TRF_LIM_HOT + ch];

            // latch settings at start so a mid-conversion write cannot split a result
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    rng_s_q[ch] <= 1'b0;
                    res_s_q[ch] <= TRF_RES_RST;
                    busy_q[ch] <= 1'b0;
                end else if (conv.start && mine_w) begin
                    rng_s_q[ch] <= range_ext_q;
                    res_s_q[ch] <= local_res_q;
                    busy_q[ch] <= 1'b1;
                end else if (conv.done && mine_w) begin
                    busy_q[ch] <= 1'b0;
                end
            end

            // results change only when a conversion finishes
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    res_hi_q[ch] <= 8'h00;
                    res_lo_q[ch] <= 8'h00;
                end else if (conv.done && mine_w) begin
                    res_hi_q[ch] <= biased_w[11:4];
                    res_lo_q[ch] <= {biased_w[3:0] & mask_w, 4'h0};
                end
            end
        end
    endgenerate

    // alarm conditions, any channel
    logic alert_cond_w;
    logic hot_cond_w;
    assign alert_cond_w = |(over_w | under_w);
    assign hot_cond_w = |hot_w;

    // open-drain pins: data held low, enable drives the pull-down
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            limit_alarm_o <= 1'b0;
            limit_alarm_oe <= 1'b0;
            overheat_flag_out_o <= 1'b0;
            overheat_flag_out_oe <= 1'b0;
        end else begin
            limit_alarm_o <= 1'b0;
            limit_alarm_oe <= alert_cond_w;
            overheat_flag_out_o <= 1'b0;
            overheat_flag_out_oe <= hot_cond_w;
        end
    end

    // write channel bookkeeping: address and data may come in either order
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] aw_addr_q;
    logic [7:0] w_data_q;
    logic w_lane0_q;
    logic aw_take_w;
    logic w_take_w;
    logic do_write_w;
    logic [3:0] wr_idx_w;
    logic aw_have_d;
    logic w_have_d;
    assign aw_take_w = s_awvalid && s_awready;
    assign w_take_w = s_wvalid && s_wready;
    // the write lands only when the previous response has been accepted
    assign do_write_w = aw_have_q && w_have_q && !s_bvalid;
    assign wr_idx_w = trf_decode(aw_addr_q);
    assign aw_have_d = (aw_have_q && !do_write_w) || aw_take_w;
    assign w_have_d = (w_have_q && !do_write_w) || w_take_w;

    // capture address and data, raise the response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 8'h00;
            w_lane0_q <= 1'b0;
            s_awready <= 1'b1;
            s_wready <= 1'b1;
            s_bvalid <= 1'b0;
            s_bresp <= TRF_RESP_OKAY;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            s_awready <= !aw_have_d;
            s_wready <= !w_have_d;
            if (aw_take_w) begin
                aw_addr_q <= s_awaddr;
            end
            if (w_take_w) begin
                w_data_q <= s_wdata[7:0];
                w_lane0_q <= s_wstrb[0];
            end
            if (do_write_w) begin
                s_bvalid <= 1'b1;
                s_bresp <= (wr_idx_w == 4'hf) ? TRF_RESP_SLVERR : TRF_RESP_OKAY;
            end else if (s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // register writes; result and status registers ignore writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            range_ext_q <= 1'b0;
            local_res_q <= TRF_RES_RST;
            for (int i = 0; i < TRF_NUM_LIM; i++) begin
                lim_q[i] <= (i == TRF_LIM_LOW || i == TRF_LIM_LOW + 2) ? TRF_LIM_LOW_RST :
                            (i >= TRF_LIM_HOT) ? TRF_LIM_HOT_RST : TRF_LIM_HIGH_RST;
            end
        end else if (do_write_w && w_lane0_q) begin
            if (wr_idx_w == TRF_OFS_CFG[5:2]) begin
                range_ext_q <= w_data_q[TRF_CFG_RANGE_BIT];
            end else if (wr_idx_w == TRF_OFS_RES[5:2]) begin
                local_res_q <= w_data_q[TRF_RES_HI_BIT:TRF_RES_LO_BIT];
            end else if (wr_idx_w >= TRF_OFS_LIM0[5:2] && wr_idx_w != 4'hf) begin
                // limits are never recoded on a range change
                lim_q[3'(wr_idx_w - TRF_OFS_LIM0[5:2])] <= w_data_q;
            end
        end
    end

    // read mux
    logic [3:0] rd_idx_w;
    logic [7:0] rd_byte_w;
    logic [7:0] stat_w;
    assign rd_idx_w = trf_decode(s_araddr);
    assign stat_w = {2'h0, busy_q[1], busy_q[0], hot_w, over_w | under_w};
    assign rd_byte_w =
        (rd_idx_w == TRF_OFS_CFG[5:2]) ? 8'({range_ext_q, 2'h0}) :
        (rd_idx_w == TRF_OFS_RES[5:2]) ? 8'(local_res_q) :
        (rd_idx_w == TRF_OFS_LOC_HI[5:2]) ? res_hi_q[TRF_CH_LOC] :
        (rd_idx_w == TRF_OFS_LOC_LO[5:2]) ? res_lo_q[TRF_CH_LOC] :
        (rd_idx_w == TRF_OFS_REM_HI[5:2]) ? res_hi_q[TRF_CH_REM] :
        (rd_idx_w == TRF_OFS_REM_LO[5:2]) ? res_lo_q[TRF_CH_REM] :
        (rd_idx_w == TRF_OFS_STAT[5:2]) ? stat_w :
        (rd_idx_w != 4'hf) ? lim_q[3'(rd_idx_w - TRF_OFS_LIM0[5:2])] : 8'h00;

    // read state machine: one address, then hold data until taken
    trf_rd_state_t rd_st_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_st_q <= TRF_RD_IDLE;
            s_arready <= 1'b1;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0000_0000;
            s_rresp <= TRF_RESP_OKAY;
        end else begin
            unique case (rd_st_q)
                TRF_RD_IDLE: begin
                    if (s_arvalid) begin
                        rd_st_q <= TRF_RD_RESP;
                        s_arready <= 1'b0;
                        s_rvalid <= 1'b1;
                        s_rdata <= {24'h00_0000, rd_byte_w};
                        s_rresp <= (rd_idx_w == 4'hf) ? TRF_RESP_SLVERR : TRF_RESP_OKAY;
                    end
                end
                TRF_RD_RESP: begin
                    if (s_rready) begin
                        rd_st_q <= TRF_RD_IDLE;
                        s_arready <= 1'b1;
                        s_rvalid <= 1'b0;
                    end
                end
                default: begin
                    rd_st_q <= TRF_RD_IDLE;
                    s_arready <= 1'b1;
                    s_rvalid <= 1'b0;
                end
            endcase
        end
    end

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic std_loc_w;
    assign std_loc_w = conv.done && !conv.chan && !rng_s_q[0];
    property p_below_zero;
        std_loc_w && conv.temp < 0 |=> res_hi_q[0] == 8'h00 && res_lo_q[0] == 8'h00;
    endproperty
    a_below_zero: assert property (p_below_zero) else $error("negative not floored");
    property p_std_sat;
        std_loc_w && conv.temp > 14'sh07ff |=> res_hi_q[0] == 8'h7f;
    endproperty
    a_std_sat: assert property (p_std_sat) else $error("standard not saturated");
    property p_ext_zero;
        conv.done && conv.chan && rng_s_q[1] && conv.temp[13:4] == 10'h000 |=> res_hi_q[1] == 8'h40;
    endproperty
    a_ext_zero: assert property (p_ext_zero) else $error("extended offset wrong");
    property p_ext_top;
        conv.done && conv.chan && rng_s_q[1] && conv.temp > 14'sh0bff |=> res_hi_q[1] == 8'hff;
    endproperty
    a_ext_top: assert property (p_ext_top) else $error("extended top wrong");
    property p_remote_frac;
        conv.done && conv.chan && conv.temp[13:11] == 3'h0 |=> res_lo_q[1] == {$past(conv.temp[3:0]), 4'h0};
    endproperty
    a_remote_frac: assert property (p_remote_frac) else $error("remote fraction lost");
    property p_local_half;
        conv.done && !conv.chan && res_s_q[0] == 2'h0 |=> res_lo_q[0][6:0] == 7'h00;
    endproperty
    a_local_half: assert property (p_local_half) else $error("half degree not truncated");
    property p_hold;
        !conv.done |=> $stable(res_hi_q[0]) && $stable(res_hi_q[1]);
    endproperty
    a_hold: assert property (p_hold) else $error("result changed without conversion");
    property p_alarm;
        ##1 limit_alarm_oe == $past(res_hi_q[0] > lim_q[TRF_LIM_HIGH] || res_hi_q[0] < lim_q[TRF_LIM_LOW] ||
            res_hi_q[1] > lim_q[TRF_LIM_HIGH + 2] || res_hi_q[1] < lim_q[TRF_LIM_LOW + 2]) && !limit_alarm_o;
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm pin mismatch");
    property p_hot;
        res_hi_q[0] > lim_q[TRF_LIM_HOT] || res_hi_q[1] > lim_q[TRF_LIM_HOT + 1] |=>
            overheat_flag_out_oe ##0 !overheat_flag_out_o;
    endproperty
    a_hot: assert property (p_hot) else $error("overheat not driven");
    c_ext_write: cover property (do_write_w && wr_idx_w == 4'h0 && w_data_q[TRF_CFG_RANGE_BIT]);
    c_alarm: cover property (limit_alarm_oe ##1 !limit_alarm_oe);
    c_read: cover property (s_rvalid && s_rready);
endmodule : trf_formatter

// [rtl/trf_pkg.sv]
// package for the temperature result formatter: register map, field layout, reset values, carriers
package trf_pkg;
    // register byte offsets on the AXI4-Lite slave
    localparam logic [7:0] TRF_OFS_CFG = 8'h00; // range select
    localparam logic [7:0] TRF_OFS_RES = 8'h04; // local resolution select
    localparam logic [7:0] TRF_OFS_LOC_HI = 8'h08; // local result, whole degrees
    localparam logic [7:0] TRF_OFS_LOC_LO = 8'h0c; // local result, fraction
    localparam logic [7:0] TRF_OFS_REM_HI = 8'h10; // remote result, whole degrees
    localparam logic [7:0] TRF_OFS_REM_LO = 8'h14; // remote result, fraction
    localparam logic [7:0] TRF_OFS_STAT = 8'h18; // live compare and busy state
    localparam logic [7:0] TRF_OFS_LIM0 = 8'h1c; // first of six limit registers
    localparam int TRF_NUM_LIM = 6;
    // limit slots: 0 local high, 1 local low, 2 remote high, 3 remote low, 4 local overheat, 5 remote overheat
    localparam int TRF_LIM_HIGH = 0;
    localparam int TRF_LIM_LOW = 1;
    localparam int TRF_LIM_HOT = 4;
    // field positions
    localparam int TRF_CFG_RANGE_BIT = 2;
    localparam int TRF_RES_HI_BIT = 1;
    localparam int TRF_RES_LO_BIT = 0;
    localparam int TRF_ST_BUSY_BIT = 4;
    // reset values
    localparam logic [7:0] TRF_LIM_HIGH_RST = 8'h55;
    localparam logic [7:0] TRF_LIM_LOW_RST = 8'h00;
    localparam logic [7:0] TRF_LIM_HOT_RST = 8'h55;
    localparam logic [1:0] TRF_RES_RST = 2'h3;
    // fixed point: signed 14 bit, 4 fraction bits (1/16 degree)
    localparam int TRF_TW = 14;
    localparam logic signed [15:0] TRF_STD_MIN = 16'sh0000; // 0.0
    localparam logic signed [15:0] TRF_STD_MAX = 16'sh07ff; // 127.9375
    localparam logic signed [15:0] TRF_EXT_MIN = -16'sh0400; // -64.0
    localparam logic signed [15:0] TRF_EXT_MAX = 16'sh0bff; // 191.9375
    localparam logic signed [15:0] TRF_EXT_OFS = 16'sh0400; // +64 degrees
    // axi answers
    localparam logic [1:0] TRF_RESP_OKAY = 2'h0;
    localparam logic [1:0] TRF_RESP_SLVERR = 2'h2;
    // channel numbers
    localparam int TRF_CH_LOC = 0;
    localparam int TRF_CH_REM = 1;
    // conversion port from the front end (same clock)
    typedef struct packed {
        logic start; // pulse: conversion begins on chan
        logic done; // pulse: temp is valid for chan
        logic chan; // 0 local, 1 remote
        logic signed [TRF_TW-1:0] temp; // measured temperature, 1/16 degree
    } trf_conv_t;
    typedef enum logic [1:0] {
        TRF_RD_IDLE = 2'b01,
        TRF_RD_RESP = 2'b10
    } trf_rd_state_t;
endpackage : trf_pkg

// [verification/trf_host_model.sv]
// axi4-lite host model standing in for the software that programs limits and reads results
`timescale 1ns/1ps
module trf_host_model (
    // clock
    input wire logic aclk,
    // write address and data
    output logic [7:0] awaddr,
    output logic [2:0] awprot,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    // write response
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    // read address and data
    output logic [7:0] araddr,
    output logic [2:0] arprot,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    // idle payloads carry junk, so a stale capture by the slave cannot pass
    initial begin
        {awaddr, araddr, wdata} = 48'h5a_a5_c3c3c3c3;
        {awprot, arprot, wstrb} = 10'h00f;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    end
    // one write: address and data offered together, each dropped once taken; ready and the answer are read
    // just after the edge, before the slave's own updates of that edge land, so they are what the edge sampled
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
        logic pa;
        logic pw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h0, d};
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (pa || pw) begin
            @(posedge aclk);
            if (pa && awready) begin
                pa = 1'b0;
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (pw && wready) begin
                pw = 1'b0;
                wvalid <= 1'b0;
                wdata <= ~{24'h0, d};
            end
        end
        // the response is taken at the edge where bvalid and bready are both high
        do begin
            @(posedge aclk);
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask : wr
    // one read: rready is held from the start until the data is taken at an edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
        end while (!arready);
        arvalid <= 1'b0;
        araddr <= ~a;
        do begin
            @(posedge aclk);
        end while (!rvalid);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : rd
endmodule : trf_host_model

// [verification/trf_formatter_bench.sv]
// self-checking bench for the temperature result formatter
`timescale 1ns/1ps
module trf_formatter_bench;
    import trf_pkg::*;
    // clock, reset, conversion port
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    trf_conv_t conv = '0;
    // bus wires and alarm pins
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [2:0] awprot, arprot;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic al_o, al_oe, oh_o, oh_oe;
    int n_fail = 0;
    int tests_run = 0;
    // board pull-ups on the shared alarm lines
    wire alarm_n = al_oe ? al_o : 1'b1;
    wire hot_n = oh_oe ? oh_o : 1'b1;
    always #2 aclk = ~aclk;
    trf_host_model i_trf_host_model (.aclk(aclk), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    trf_formatter i_trf_formatter (.aclk(aclk), .aresetn(aresetn), .conv(conv), .s_awaddr(awaddr),
        .s_awprot(awprot), .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb),
        .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
        .s_araddr(araddr), .s_arprot(arprot), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
        .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .limit_alarm_o(al_o),
        .limit_alarm_oe(al_oe), .overheat_flag_out_o(oh_o), .overheat_flag_out_oe(oh_oe));
    // count a comparison, report a mismatch at once
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    // register access through the host model, response always compared
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        i_trf_host_model.rd(a, d, r);
        chk({30'h0, r}, {30'h0, TRF_RESP_OKAY}, "read response");
        chk(d, exp, "read data");
    endtask : rd_chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] r;
        i_trf_host_model.wr(a, d, r);
        chk({30'h0, r}, {30'h0, TRF_RESP_OKAY}, "write response");
    endtask : wr
    // start and done are split so settings can change in mid-conversion
    task automatic conv_start(input logic ch);
        @(posedge aclk);
        conv.start <= 1'b1;
        conv.chan <= ch;
        @(posedge aclk);
        conv.start <= 1'b0;
    endtask : conv_start
    task automatic conv_done(input logic ch, input logic signed [13:0] t);
        @(posedge aclk);
        conv.done <= 1'b1;
        conv.chan <= ch;
        conv.temp <= t;
        @(posedge aclk);
        conv.done <= 1'b0;
        conv.temp <= ~t;
        repeat (3) @(posedge aclk);
    endtask : conv_done
    task automatic measure(input logic ch, input int t);
        conv_start(ch);
        conv_done(ch, 14'(t));
    endtask : measure
    // both result bytes of one channel
    task automatic chk_res(input logic ch, input logic [7:0] hi, input logic [7:0] lo);
        rd_chk(ch ? TRF_OFS_REM_HI : TRF_OFS_LOC_HI, {24'h0, hi});
        rd_chk(ch ? TRF_OFS_REM_LO : TRF_OFS_LOC_LO, {24'h0, lo});
    endtask : chk_res
    // let an alarm update land, then look mid-cycle
    task automatic pins(input logic al, input logic hot);
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk({31'h0, alarm_n}, {31'h0, al}, "alarm line");
        chk({31'h0, hot_n}, {31'h0, hot}, "overheat line");
    endtask : pins
    task automatic t_reset;
        logic [31:0] d;
        logic [1:0] r;
        rd_chk(TRF_OFS_CFG, 32'h0);
        wr(TRF_OFS_LOC_HI, 8'h33);
        chk_res(0, 8'h00, 8'h00);
        rd_chk(TRF_OFS_LIM0, {24'h0, TRF_LIM_HIGH_RST});
        i_trf_host_model.rd(8'h40, d, r);
        chk({30'h0, r}, {30'h0, TRF_RESP_SLVERR}, "unmapped response");
        chk(d, 32'h0, "unmapped data");
        i_trf_host_model.wr(8'h41, 8'h04, r);
        chk({30'h0, r}, {30'h0, TRF_RESP_SLVERR}, "misaligned write response");
        rd_chk(TRF_OFS_CFG, 32'h0);
    endtask : t_reset
    task automatic t_std;
        measure(0, 408);
        chk_res(0, 8'h19, 8'h80);
        measure(0, -80);
        chk_res(0, 8'h00, 8'h00);
        measure(0, 3200);
        chk_res(0, 8'h7f, 8'hf0);
        measure(1, 409);
        chk_res(1, 8'h19, 8'h90);
    endtask : t_std
    // every local resolution code, remote unaffected by the coarsest one
    task automatic t_res;
        for (int r = 0; r < 4; r++) begin
            wr(TRF_OFS_RES, 8'(r));
            measure(0, 175);
            chk_res(0, 8'h0a, 8'hf0 << (3 - r));
            if (r == 0) begin
                measure(1, 175);
                chk_res(1, 8'h0a, 8'hf0);
            end
        end
    endtask : t_res
    task automatic t_ext;
        int tv[7] = '{-800, 0, 3071, -1120, 4000, -400, 2400};
        logic [7:0] ev[7] = '{8'h0e, 8'h40, 8'hff, 8'h00, 8'hff, 8'h27, 8'hd6};
        wr(TRF_OFS_CFG, 8'h04);
        rd_chk(TRF_OFS_CFG, 32'h4);
        rd_chk(TRF_OFS_LOC_HI, 32'h0a);
        for (int i = 0; i < 7; i++) begin
            measure(0, tv[i]);
            rd_chk(TRF_OFS_LOC_HI, {24'h0, ev[i]});
        end
        rd_chk(TRF_OFS_LOC_LO, 32'h0);
        conv_start(0);
        rd_chk(TRF_OFS_STAT, 32'h15);
        wr(TRF_OFS_CFG, 8'h00);
        conv_done(0, 14'h0000);
        rd_chk(TRF_OFS_LOC_HI, 32'h40);
        measure(0, 0);
        rd_chk(TRF_OFS_LOC_HI, 32'h00);
    endtask : t_ext
    task automatic t_alarm;
        pins(1'b1, 1'b1);
        measure(0, 1440);
        pins(1'b0, 1'b0);
        rd_chk(TRF_OFS_STAT, 32'h05);
        wr(TRF_OFS_LIM0 + 8'h10, 8'h60);
        pins(1'b0, 1'b1);
        wr(TRF_OFS_LIM0, 8'h70);
        pins(1'b1, 1'b1);
        wr(TRF_OFS_LIM0 + 8'h04, 8'h20);
        measure(0, 256);
        pins(1'b0, 1'b1);
        measure(1, 1600);
        pins(1'b0, 1'b0);
        rd_chk(TRF_OFS_STAT, 32'h0b);
        wr(TRF_OFS_CFG, 8'h04);
        rd_chk(TRF_OFS_LIM0 + 8'h04, 32'h20);
        rd_chk(TRF_OFS_LIM0 + 8'h10, 32'h60);
    endtask : t_alarm
    task automatic report_and_stop;
        $display("mismatches %0d, comparisons %0d", n_fail, tests_run);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop
    // main sequence after five reset cycles
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_std();
        t_res();
        t_ext();
        t_alarm();
        report_and_stop();
    end
    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        $display("CHECK FAILED at %0t: run hung", $time);
        report_and_stop();
    end
endmodule : trf_formatter_bench
